// ===== design/sccp_map.svh
// Register offsets, field positions and counts for the command pointer block
`ifndef SCCP_MAP_SVH
`define SCCP_MAP_SVH

// APB byte offsets and write register window address fields
`define SCCP_CTRL_A_OFS    8'h00
`define SCCP_CTRL_B_OFS    8'h04
`define SCCP_WREG_WIN_TAG  2'h1
`define SCCP_WREG_WIN_MSB  7
`define SCCP_WREG_WIN_LSB  6
`define SCCP_WREG_CH_BIT   5
`define SCCP_WREG_IDX_MSB  4
`define SCCP_WREG_IDX_LSB  2

// Command register fields
`define SCCP_SEL_MSB       2
`define SCCP_SEL_LSB       0
`define SCCP_CMD_MSB       5
`define SCCP_CMD_LSB       3
`define SCCP_CRC_MSB       7
`define SCCP_CRC_LSB       6

// Selector values
`define SCCP_SEL_CMD       3'h0
`define SCCP_SEL_RR1       3'h1
`define SCCP_SEL_WR1       3'h1
`define SCCP_SEL_WR4       3'h4

// Write register fields steering this block
`define SCCP_WR1_EXT_IE    0
`define SCCP_WR4_MODE_MSB  5
`define SCCP_WR4_MODE_LSB  4
`define SCCP_WR4_FRAME     2'h2

// Read data layout
`define SCCP_RR0_PEND_BIT  3
`define SCCP_RR_DATA_W     8

// Abort run length in bit times
`define SCCP_ABORT_ONES    4'h8

// Reset values
`define SCCP_SEL_RESET     3'h0

`endif

// ===== design/sccp_pkg.sv
// Types shared by the command pointer block
package sccp_pkg;

	typedef enum logic [2:0]
	{
		CMD_NULL          = 3'h0,
		CMD_SEND_ABORT    = 3'h1,
		CMD_RESET_EXT     = 3'h2,
		CMD_CHAN_RESET    = 3'h3,
		CMD_EN_RX_NEXT    = 3'h4,
		CMD_RESET_TX_PEND = 3'h5,
		CMD_ERROR_RESET   = 3'h6,
		CMD_RETURN_INT    = 3'h7
	} cmd_t;

	typedef enum logic [1:0]
	{
		CRC_NONE      = 2'h0,
		CRC_RX_CHECK  = 2'h1,
		CRC_TX_GEN    = 2'h2,
		CRC_EOM_LATCH = 2'h3
	} crc_code_t;

	typedef struct packed
	{
		logic [2:0] ext_status;
		logic       parity_err;
		logic       overrun_err;
	} chan_in_t;

	typedef struct packed
	{
		logic tx_abort;
		logic ext_int_pending;
		logic reset_rx_crc;
		logic reset_tx_crc;
		logic reset_eom_latch;
		logic rx_int_next;
		logic reset_tx_int_pending;
		logic chan_reset;
	} chan_out_t;

	typedef struct packed
	{
		logic [2:0] selector;
		logic       ext_int_en;
		logic       frame_mode;
		logic       status_latched;
		logic [2:0] status_rr0;
		logic [1:0] err_rr1;
		logic [3:0] abort_cnt;
		chan_out_t  out;
	} chan_state_t;

	typedef struct packed
	{
		chan_state_t [1:0] ch;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic              prio_reset;
		logic              ius_clear;
	} top_state_t;

endpackage : sccp_pkg

// ===== design/serial_channel_command_pointer.sv
// Command register and register selector of both serial channels, APB slave
//
// Contract
// - Eight write registers; others take selector then data
// - Reset or channel reset clears the selector
// - Selector returns to zero after other access
// - Selector picks next read or write register
// - Middle three bits decode eight commands
// - Command codes map to listed channel actions
// - Null command only loads the selector
// - Send abort in frame mode sends ones
// - Status bits latched until reset-status command
// - Channel reset; channel A also resets priority
// - Command and checksum code in first byte
// - Top two bits give checksum reset codes
// - Error reset clears parity and overrun flags
// - Return command on channel A clears service latch
`include "sccp_map.svh"
`timescale 1ns/10ps

module serial_channel_command_pointer #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Channel events and bit timing
	input  wire logic                 bit_tick,
	input  wire sccp_pkg::chan_in_t   ch_in_a,
	input  wire sccp_pkg::chan_in_t   ch_in_b,
	// Channel command outputs
	output sccp_pkg::chan_out_t       ch_out_a,
	output sccp_pkg::chan_out_t       ch_out_b,
	// Shared interrupt logic controls
	output logic                      prio_reset,
	output logic                      ius_clear
);

	sccp_pkg::top_state_t st_reg;
	sccp_pkg::top_state_t st_next;

	logic                            setup_phase;
	logic                            first_access;
	logic                            done;
	logic                            hit_ctrl_a;
	logic                            hit_ctrl_b;
	logic                            hit_wreg;
	logic                            hit_ch;
	logic                            wr_a;
	logic                            wr_b;
	logic                            rd_a;
	logic                            rd_b;
	logic [7:0]                      wbyte;
	logic                            mem_we;
	logic [3:0]                      mem_waddr;
	logic [3:0]                      mem_raddr;
	logic [7:0]                      mem_rdata;
	sccp_pkg::chan_state_t           sel_ch;

	// One channel's next state; each channel calls it, giving one decoder per channel
	function automatic sccp_pkg::chan_state_t chan_step(
		input sccp_pkg::chan_state_t s,
		input logic                  wr,
		input logic                  rd,
		input logic [7:0]            b,
		input sccp_pkg::chan_in_t    ev,
		input logic                  tick
	);
		sccp_pkg::chan_state_t n;
		sccp_pkg::cmd_t        cmd;
		sccp_pkg::crc_code_t   crc;
		n   = s;
		cmd = sccp_pkg::cmd_t'(b[`SCCP_CMD_MSB:`SCCP_CMD_LSB]);
		crc = sccp_pkg::crc_code_t'(b[`SCCP_CRC_MSB:`SCCP_CRC_LSB]);
		n.out.reset_rx_crc         = 1'b0;
		n.out.reset_tx_crc         = 1'b0;
		n.out.reset_eom_latch      = 1'b0;
		n.out.rx_int_next          = 1'b0;
		n.out.reset_tx_int_pending = 1'b0;
		n.out.chan_reset           = 1'b0;
		if (s.abort_cnt != 4'h0 && tick)
		begin
			n.abort_cnt = s.abort_cnt - 4'h1;
		end
		if (wr && s.selector == `SCCP_SEL_CMD)
		begin
			n.selector = b[`SCCP_SEL_MSB:`SCCP_SEL_LSB];
			case (cmd)
				sccp_pkg::CMD_NULL:
				begin
				end
				sccp_pkg::CMD_SEND_ABORT:
				begin
					if (s.frame_mode)
					begin
						n.abort_cnt = `SCCP_ABORT_ONES;
					end
				end
				sccp_pkg::CMD_RESET_EXT:
				begin
					n.status_latched      = 1'b0;
					n.out.ext_int_pending = 1'b0;
				end
				sccp_pkg::CMD_CHAN_RESET:
				begin
					// Config shadows drop too; host must reprogram the channel
					n                = '0;
					n.selector       = `SCCP_SEL_RESET;
					n.out.chan_reset = 1'b1;
				end
				sccp_pkg::CMD_EN_RX_NEXT:
				begin
					n.out.rx_int_next = 1'b1;
				end
				sccp_pkg::CMD_RESET_TX_PEND:
				begin
					n.out.reset_tx_int_pending = 1'b1;
				end
				sccp_pkg::CMD_ERROR_RESET:
				begin
					n.err_rr1 = 2'h0;
				end
				sccp_pkg::CMD_RETURN_INT:
				begin
				end
				default:
				begin
				end
			endcase
			if (cmd != sccp_pkg::CMD_CHAN_RESET)
			begin
				case (crc)
					sccp_pkg::CRC_NONE:      n.out.reset_rx_crc    = 1'b0;
					sccp_pkg::CRC_RX_CHECK:  n.out.reset_rx_crc    = 1'b1;
					sccp_pkg::CRC_TX_GEN:    n.out.reset_tx_crc    = 1'b1;
					sccp_pkg::CRC_EOM_LATCH: n.out.reset_eom_latch = 1'b1;
					default:                 n.out.reset_rx_crc    = 1'b0;
				endcase
			end
		end
		else if (wr)
		begin
			if (s.selector == `SCCP_SEL_WR1)
			begin
				n.ext_int_en = b[`SCCP_WR1_EXT_IE];
			end
			if (s.selector == `SCCP_SEL_WR4)
			begin
				n.frame_mode = (b[`SCCP_WR4_MODE_MSB:`SCCP_WR4_MODE_LSB] == `SCCP_WR4_FRAME);
			end
			n.selector = `SCCP_SEL_CMD;
		end
		else if (rd && s.selector != `SCCP_SEL_CMD)
		begin
			n.selector = `SCCP_SEL_CMD;
		end
		// Events come after the clears so a same-cycle event is kept
		if (ev.parity_err)
		begin
			n.err_rr1[0] = 1'b1;
		end
		if (ev.overrun_err)
		begin
			n.err_rr1[1] = 1'b1;
		end
		if (!n.status_latched)
		begin
			n.status_rr0 = ev.ext_status;
			if (ev.ext_status != s.status_rr0 && n.ext_int_en)
			begin
				n.status_latched      = 1'b1;
				n.out.ext_int_pending = 1'b1;
			end
		end
		n.out.tx_abort = (n.abort_cnt != 4'h0);
		return n;
	endfunction : chan_step

	// Read value of the selected read register of one channel
	function automatic logic [31:0] read_ctrl(input sccp_pkg::chan_state_t s);
		logic [31:0] v;
		v = 32'h0;
		if (s.selector == `SCCP_SEL_CMD)
		begin
			v[2:0]               = s.status_rr0;
			v[`SCCP_RR0_PEND_BIT] = s.out.ext_int_pending;
		end
		else if (s.selector == `SCCP_SEL_RR1)
		begin
			v[1:0] = s.err_rr1;
		end
		return v;
	endfunction : read_ctrl

	assign setup_phase  = psel && !penable;
	assign first_access = psel && penable && !st_reg.pready;
	assign done         = psel && penable && st_reg.pready;
	assign hit_ctrl_a   = (paddr == `SCCP_CTRL_A_OFS);
	assign hit_ctrl_b   = (paddr == `SCCP_CTRL_B_OFS);
	assign hit_wreg     = (paddr[`SCCP_WREG_WIN_MSB:`SCCP_WREG_WIN_LSB] == `SCCP_WREG_WIN_TAG)
		&& (paddr[1:0] == 2'h0);
	assign hit_ch       = paddr[`SCCP_WREG_CH_BIT];
	assign wbyte        = pwdata[7:0];

	// Byte lane 0 carries the control byte; a write without it is dropped
	assign wr_a = done && pwrite && pstrb[0] && hit_ctrl_a;
	assign wr_b = done && pwrite && pstrb[0] && hit_ctrl_b;
	assign rd_a = done && !pwrite && hit_ctrl_a;
	assign rd_b = done && !pwrite && hit_ctrl_b;

	assign sel_ch    = hit_ctrl_b ? st_reg.ch[1] : st_reg.ch[0];
	assign mem_we    = (wr_a || wr_b) && (sel_ch.selector != `SCCP_SEL_CMD);
	assign mem_waddr = {hit_ctrl_b, sel_ch.selector};
	assign mem_raddr = {hit_ch, paddr[`SCCP_WREG_IDX_MSB:`SCCP_WREG_IDX_LSB]};

	wreg_mem #(
		.DEPTH  (16),
		.WIDTH  (8),
		.ADDR_W (4)
	) u_wreg_mem (
		.mclk  (mclk),
		.nrst  (nrst),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (wbyte),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	always_comb
	begin
		st_next            = st_reg;
		st_next.prio_reset = 1'b0;
		st_next.ius_clear  = 1'b0;
		// Two access cycles so the memory read can land in a flop
		st_next.pready     = first_access;
		if (setup_phase || done)
		begin
			st_next.pslverr = 1'b0;
			st_next.prdata  = 32'h0;
		end
		if (first_access)
		begin
			if (hit_ctrl_a || hit_ctrl_b)
			begin
				st_next.prdata = pwrite ? 32'h0 : read_ctrl(sel_ch);
			end
			else if (hit_wreg && !pwrite)
			begin
				st_next.prdata = {24'h0, mem_rdata};
			end
			else
			begin
				st_next.pslverr = 1'b1;
			end
		end
		// Independent selector and decoder per channel
		st_next.ch[0] = chan_step(st_reg.ch[0], wr_a, rd_a, wbyte, ch_in_a, bit_tick);
		st_next.ch[1] = chan_step(st_reg.ch[1], wr_b, rd_b, wbyte, ch_in_b, bit_tick);
		if (wr_a && st_reg.ch[0].selector == `SCCP_SEL_CMD)
		begin
			if (wbyte[`SCCP_CMD_MSB:`SCCP_CMD_LSB] == sccp_pkg::CMD_CHAN_RESET)
			begin
				st_next.prio_reset = 1'b1;
			end
			// Channel B issuing this code is ignored
			if (wbyte[`SCCP_CMD_MSB:`SCCP_CMD_LSB] == sccp_pkg::CMD_RETURN_INT)
			begin
				st_next.ius_clear = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign prdata     = st_reg.prdata;
	assign pready     = st_reg.pready;
	assign pslverr    = st_reg.pslverr;
	assign ch_out_a   = st_reg.ch[0].out;
	assign ch_out_b   = st_reg.ch[1].out;
	assign prio_reset = st_reg.prio_reset;
	assign ius_clear  = st_reg.ius_clear;

endmodule : serial_channel_command_pointer

// ===== design/wreg_mem.sv
// Small memory holding the write registers of both channels
`timescale 1ns/10ps

module wreg_mem #(
	parameter int DEPTH  = 16,
	parameter int WIDTH  = 8,
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// Write side
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [WIDTH-1:0]  wdata,
	// Read side
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [WIDTH-1:0]  rdata
);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] cells;
		logic [WIDTH-1:0]            rdata;
	} mem_state_t;

	mem_state_t mem_reg;
	mem_state_t mem_next;

	always_comb
	begin
		mem_next       = mem_reg;
		mem_next.rdata = mem_reg.cells[raddr];
		if (we)
		begin
			mem_next.cells[waddr] = wdata;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			mem_reg <= '0;
		end
		else
		begin
			mem_reg <= mem_next;
		end
	end

	assign rdata = mem_reg.rdata;

endmodule : wreg_mem

// ===== tb/host_apb.sv
// Host model issuing control port transfers over APB
`timescale 1ns/10ps
module host_apb (
	// Clock
	input  wire logic        mclk,
	// Request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	// Answer
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata
);
	logic [31:0] rdat;
	logic        rerr;
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	end
	// Bytes go whole, selector byte first; frame mode is never set
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge mclk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		pstrb   <= 4'h1;
		@(posedge mclk);
		penable <= 1'h1;
		do
			@(posedge mclk);
		while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
endmodule : host_apb

// ===== tb/sccp_chk.sv
// Port checker for the command pointer block
`timescale 1ns/10ps
module sccp_chk #(
	parameter int ADDR_W = 8
) (
	input wire logic              mclk,
	input wire logic              nrst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [3:0]        pstrb,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire sccp_pkg::chan_out_t ch_out_a,
	input wire sccp_pkg::chan_out_t ch_out_b,
	input wire logic              prio_reset,
	input wire logic              ius_clear
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire logic       done = psel & penable & pready & pwrite & pstrb[0];
	wire logic       wa   = done & (paddr == 8'h00);
	wire logic       wb   = done & (paddr == 8'h04);
	wire logic [2:0] c    = pwdata[5:3];
	sequence s_acc;
		psel && !penable ##1 !pready;
	endsequence
	property p_rdy; s_acc |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_null; wa && c == 3'h0 |=> ch_out_a[2:0] == 3'h0 && !prio_reset; endproperty
	a_null: assert property (p_null) else $error("null acted");
	property p_prio; prio_reset |-> $past(wa && c == 3'h3); endproperty
	a_prio: assert property (p_prio) else $error("stray prio");
	property p_ius; ius_clear |-> $past(wa && c == 3'h7); endproperty
	a_ius: assert property (p_ius) else $error("stray ius");
	property p_crst; ch_out_b.chan_reset |-> $past(wb && c == 3'h3); endproperty
	a_crst: assert property (p_crst) else $error("stray reset b");
	property p_rx; ch_out_a.rx_int_next |-> $past(wa && c == 3'h4); endproperty
	a_rx: assert property (p_rx) else $error("stray rx");
	property p_crc; ch_out_a.reset_rx_crc |-> $past(wa && pwdata[7:6] == 2'h1); endproperty
	a_crc: assert property (p_crc) else $error("stray crc");
	property p_eom; ch_out_b.reset_eom_latch |-> $past(wb && pwdata[7:6] == 2'h3); endproperty
	a_eom: assert property (p_eom) else $error("stray eom");
	property p_abt; $rose(ch_out_a.tx_abort) |-> $past(wa && c == 3'h1); endproperty
	a_abt: assert property (p_abt) else $error("stray abort");
endmodule : sccp_chk

bind serial_channel_command_pointer sccp_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk),
	.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .pstrb(pstrb),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .ch_out_a(ch_out_a),
	.ch_out_b(ch_out_b), .prio_reset(prio_reset), .ius_clear(ius_clear));

// ===== tb/serial_channel_command_pointer_tb.sv
// Self-checking bench for the command pointer block
`timescale 1ns/10ps
module serial_channel_command_pointer_tb;
	typedef struct packed {logic [7:0] a, d, oa, ob; logic [1:0] pi;} row_t;
	localparam row_t rows [14] = '{
		'{8'h00, 8'h00, 8'h00, 8'h00, 2'h0}, '{8'h00, 8'h08, 8'h00, 8'h00, 2'h0},
		'{8'h00, 8'h10, 8'h00, 8'h00, 2'h0}, '{8'h00, 8'h18, 8'h01, 8'h00, 2'h2},
		'{8'h00, 8'h20, 8'h04, 8'h00, 2'h0}, '{8'h00, 8'h28, 8'h02, 8'h00, 2'h0},
		'{8'h00, 8'h30, 8'h00, 8'h00, 2'h0}, '{8'h00, 8'h38, 8'h00, 8'h00, 2'h1},
		'{8'h00, 8'h40, 8'h20, 8'h00, 2'h0}, '{8'h00, 8'h80, 8'h10, 8'h00, 2'h0},
		'{8'h00, 8'hc0, 8'h08, 8'h00, 2'h0}, '{8'h04, 8'h18, 8'h00, 8'h01, 2'h0},
		'{8'h04, 8'h38, 8'h00, 8'h00, 2'h0}, '{8'h04, 8'h20, 8'h00, 8'h04, 2'h0}};
	logic                mclk = 1'h0;
	logic                nrst = 1'h0;
	logic                bit_tick = 1'h0;
	logic                psel, penable, pwrite, pready, pslverr, prio_reset, ius_clear;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata;
	logic [3:0]          pstrb;
	sccp_pkg::chan_in_t  in_a = 5'h00;
	sccp_pkg::chan_in_t  in_b = 5'h00;
	sccp_pkg::chan_out_t out_a, out_b;
	int                  fail_count = 0;
	int                  cmp_count = 0;
	always #2 mclk = ~mclk;
	host_apb h (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.pslverr(pslverr), .prdata(prdata));
	serial_channel_command_pointer dut (.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bit_tick(bit_tick), .ch_in_a(in_a), .ch_in_b(in_b), .ch_out_a(out_a),
		.ch_out_b(out_b), .prio_reset(prio_reset), .ius_clear(ius_clear));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	// Pulses last one cycle, so look right after the completion edge
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		h.xfer(a, 1'h1, d);
		#1;
	endtask : w
	task automatic r(input logic [7:0] a, input logic [31:0] e);
		h.xfer(a, 1'h0, 8'h00);
		chk(h.rdat, e);
	endtask : r
	task automatic pulse(input logic [4:0] v);
		@(posedge mclk) in_a <= v;
		@(posedge mclk) in_a <= 5'h00;
	endtask : pulse
	initial
	begin
		#100000;
		fail_count++;
		results;
	end
	initial
	begin
		repeat (8) @(posedge mclk);
		nrst <= 1'h1;
		foreach (rows[i])
		begin
			w(rows[i].a, rows[i].d);
			chk(out_a, rows[i].oa);
			chk(out_b, rows[i].ob);
			chk({prio_reset, ius_clear}, rows[i].pi);
			repeat (4) @(posedge mclk);
		end
		w(8'h00, 8'h01);
		w(8'h00, 8'h01);
		r(8'h44, 32'h1);
		w(8'h00, 8'h28);
		chk(out_a, 8'h02);
		pulse(5'h03);
		w(8'h00, 8'h01);
		r(8'h00, 32'h3);
		r(8'h00, 32'h0);
		pulse(5'h02);
		w(8'h00, 8'h30);
		w(8'h00, 8'h01);
		r(8'h00, 32'h0);
		pulse(5'h14);
		r(8'h00, 32'h0d);
		chk(out_a, 8'h40);
		@(posedge mclk) in_a <= 5'h14;
		w(8'h00, 8'h10);
		r(8'h00, 32'h05);
		w(8'h00, 8'h21);
		chk(out_a, 8'h04);
		r(8'h00, 32'h0);
		r(8'h00, 32'h05);
		w(8'h04, 8'h01);
		w(8'h00, 8'h20);
		chk(out_a, 8'h04);
		w(8'h04, 8'h20);
		chk(out_b, 8'h00);
		// Channel reset drops the interrupt enable; host must write it again
		w(8'h00, 8'h18);
		chk(out_a, 8'h01);
		repeat (4) @(posedge mclk);
		w(8'h00, 8'h01);
		w(8'h00, 8'h01);
		pulse(5'h00);
		r(8'h00, 32'h08);
		w(8'h00, 8'h01);
		@(posedge mclk) nrst <= 1'h0;
		@(posedge mclk) nrst <= 1'h1;
		w(8'h00, 8'h20);
		chk(out_a, 8'h04);
		h.xfer(8'h08, 1'h0, 8'h00);
		chk(h.rerr, 1'h1);
		h.xfer(8'h40, 1'h1, 8'h01);
		chk(h.rerr, 1'h1);
		results;
	end
endmodule : serial_channel_command_pointer_tb
